// [verilog/snsc_session.sv]
`default_nettype none
module snsc_session import snsc_pkg::*; #(
	parameter int TICK_CYC_P = TICK_CYC,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire cfg_t CFG,
	input wire logic SER_RX_VALID,
	input wire logic [7:0] SER_RX_DATA,
	output logic SER_RX_READY,
	output logic SER_TX_VALID,
	output logic [7:0] SER_TX_DATA,
	input wire logic SER_TX_READY,
	input wire net_stat_t NET_STAT,
	output net_cmd_t NET_CMD,
	output logic NET_TX_VALID,
	output logic [7:0] NET_TX_DATA,
	input wire logic NET_TX_READY,
	output peer_t NET_DST,
	output logic CFG_CMD_STB,
	output logic CFG_WARN,
	output sess_st_t SESSION_ST
);
	localparam int TW = $clog2(TICK_CYC_P + 1);
	localparam int CW = $clog2(DEPTH + 1);

	logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
	logic [6:0] sub_reg, sub_next;
	logic [15:0] idle_s_reg, idle_s_next, frame_reg, frame_next;
	sess_st_t st_reg, st_next;
	parse_st_t ps_reg, ps_next;
	net_cmd_t cmd_reg, cmd_next;
	logic [15:0] evt_cnt_reg, evt_cnt_next;
	logic [1:0] plus_reg, plus_next;
	logic [7:0] cmd_ch_reg, cmd_ch_next;
	logic boot_reg, boot_next, cfg_stb_reg, cfg_stb_next, warn_reg, warn_next;
	logic conn_go_reg, conn_go_next, noc_go_reg, noc_go_next;
	logic rx_rdy_reg, rx_rdy_next, tx_valid_reg, tx_valid_next;
	logic [7:0] tx_data_reg, tx_data_next;
	logic [10:0] udp_cnt_reg, udp_cnt_next;
	logic learned_reg, learned_next;
	peer_t dst_reg, dst_next;
	logic pc_reg, pc_next, pn_reg, pn_next, busy_reg, busy_next, sel_reg, sel_next;
	logic [3:0] idx_reg, idx_next;
	logic stx_v_reg, stx_v_next;
	logic [7:0] stx_d_reg, stx_d_next;
	logic tick, act, rx_take, is_at, is_udp, to_parser, discard, trig, exec, escape, to_hit;
	logic fifo_push, fifo_pop, fifo_in_rdy, fifo_out_valid, learn, gate, size_hit, idle_hit;
	logic [7:0] fifo_out_data;
	logic [CW-1:0] fifo_level;
	logic [10:0] blk;
	logic send_go;

	// ----------------------------------------
	// byte routing
	// ----------------------------------------
	assign rx_take = SER_RX_VALID && rx_rdy_reg;
	assign is_at = (CFG.mode == M_ATCMD);
	assign is_udp = (CFG.mode == M_UDP);
	assign to_parser = is_at && (st_reg != ST_ONLINE);
	assign discard = !is_at && !is_udp && (st_reg != ST_ONLINE) && (CFG.event_bytes == '0);
	assign fifo_push = rx_take && !to_parser && !discard;
	assign exec = to_parser && rx_take && (ps_reg == PS_EOL) && (SER_RX_DATA == CH_CR);
	assign escape = is_at && (st_reg == ST_ONLINE) && rx_take && (SER_RX_DATA == CH_PLUS)
		&& (plus_reg == ESC_LAST);
	assign trig = (CFG.event_bytes == '0) ? (CFG.mode == M_CLIENT || boot_reg)
		: (evt_cnt_reg >= CFG.event_bytes || !fifo_in_rdy);
	assign to_hit = (st_reg == ST_ONLINE || st_reg == ST_CMD) && (CFG.timeout_s != '0)
		&& (idle_s_reg >= CFG.timeout_s);

	snsc_fifo #(.W(8), .D(DEPTH)) u_fifo (
		.clk(MCLK),
		.rst_b(RST_B),
		.in_valid(fifo_push),
		.in_data(SER_RX_DATA),
		.in_ready(fifo_in_rdy),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(fifo_pop),
		.level(fifo_level)
	);

	// ----------------------------------------
	// timebase
	// ----------------------------------------
	assign tick = (tick_cnt_reg == TW'(TICK_CYC_P - 1));
	assign act = rx_take || (tx_valid_reg && NET_TX_READY) || NET_STAT.rx_act;

	always_comb begin
		tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;
		sub_next = sub_reg;
		idle_s_next = idle_s_reg;
		if (act || !(st_reg == ST_ONLINE || st_reg == ST_CMD)) begin
			sub_next = '0;
			idle_s_next = '0;
		end else if (tick) begin
			if (sub_reg == 7'(TICKS_PER_SEC - 1)) begin
				sub_next = '0;
				if (idle_s_reg != 16'hFFFF) idle_s_next = idle_s_reg + 16'h0001;
			end else begin
				sub_next = sub_reg + 7'h01;
			end
		end
		frame_next = frame_reg;
		if (rx_take) begin
			frame_next = '0;
		end else if (tick && frame_reg != 16'hFFFF) begin
			frame_next = frame_reg + 16'h0001;
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			tick_cnt_reg <= '0;
			sub_reg <= '0;
			idle_s_reg <= '0;
			frame_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
			sub_reg <= sub_next;
			idle_s_reg <= idle_s_next;
			frame_reg <= frame_next;
		end
	end

	// ----------------------------------------
	// session control and command parser
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		ps_next = ps_reg;
		cmd_next = '0;
		evt_cnt_next = evt_cnt_reg;
		plus_next = '0;
		cmd_ch_next = cmd_ch_reg;
		boot_next = boot_reg;
		cfg_stb_next = exec && (cmd_ch_reg == CH_PLUS);
		warn_next = (CFG.event_bytes > EVT_REC_MAX);
		conn_go_next = 1'b0;
		noc_go_next = 1'b0;
		rx_rdy_next = (fifo_level <= CW'(DEPTH - 2));
		if (fifo_push && st_reg != ST_ONLINE && evt_cnt_reg != 16'hFFFF) begin
			evt_cnt_next = evt_cnt_reg + 16'h0001;
		end
		if (is_at && st_reg == ST_ONLINE && rx_take && SER_RX_DATA == CH_PLUS) begin
			plus_next = plus_reg + 2'h1;
		end else if (!(is_at && st_reg == ST_ONLINE && !rx_take)) begin
			plus_next = '0;
		end else begin
			plus_next = plus_reg;
		end
		if (to_parser && rx_take) begin
			case (ps_reg)
				PS_A: if ((SER_RX_DATA & CASE_MASK) == CH_A) ps_next = PS_T;
				PS_T: begin
					if ((SER_RX_DATA & CASE_MASK) == CH_T) ps_next = PS_C;
					else if ((SER_RX_DATA & CASE_MASK) != CH_A) ps_next = PS_A;
				end
				PS_C: begin
					cmd_ch_next = SER_RX_DATA;
					ps_next = (SER_RX_DATA == CH_CR) ? PS_A : PS_EOL;
				end
				PS_EOL: if (SER_RX_DATA == CH_CR) ps_next = PS_A;
				default: ps_next = PS_A;
			endcase
		end
		case (st_reg)
			ST_IDLE: begin
				if (is_at) begin
					if (exec && (cmd_ch_reg & CASE_MASK) == CH_A) begin
						st_next = ST_LISTEN;
					end else if (exec && (cmd_ch_reg & CASE_MASK) == CH_D) begin
						st_next = ST_SYN;
						cmd_next.connect = 1'b1;
					end
				end else if (CFG.mode == M_CLIENT) begin
					if (trig) begin
						st_next = ST_SYN;
						cmd_next.connect = 1'b1;
						boot_next = 1'b0;
					end
				end else if (!is_udp) begin
					st_next = ST_LISTEN;
				end
			end
			ST_LISTEN: begin
				if (NET_STAT.established) begin
					st_next = ST_ONLINE;
					conn_go_next = is_at;
				end else if (CFG.mode == M_SRVCLI && trig) begin
					st_next = ST_SYN;
					cmd_next.connect = 1'b1;
					boot_next = 1'b0;
				end
			end
			ST_SYN: begin
				if (NET_STAT.established) begin
					st_next = ST_ONLINE;
					conn_go_next = is_at;
				end else if (NET_STAT.closed) begin
					st_next = ST_IDLE;
				end
			end
			ST_ONLINE: begin
				if (NET_STAT.closed) begin
					st_next = ST_IDLE;
					noc_go_next = is_at;
				end else if (to_hit) begin
					st_next = ST_CLOSING;
					cmd_next.fin = 1'b1;
				end else if (escape) begin
					st_next = ST_CMD;
				end
			end
			ST_CMD: begin
				if (NET_STAT.closed) begin
					st_next = ST_IDLE;
					noc_go_next = 1'b1;
				end else if (to_hit || (exec && (cmd_ch_reg & CASE_MASK) == CH_H)) begin
					st_next = ST_CLOSING;
					cmd_next.fin = 1'b1;
				end else if (exec && (cmd_ch_reg & CASE_MASK) == CH_O) begin
					st_next = ST_ONLINE;
				end
			end
			ST_CLOSING: begin
				if (NET_STAT.closed) begin
					st_next = ST_IDLE;
					noc_go_next = is_at;
				end
			end
			default: st_next = ST_IDLE;
		endcase
		if (st_next == ST_IDLE && st_reg != ST_IDLE) evt_cnt_next = '0;
		cmd_next.listen = (st_next == ST_LISTEN);
		cmd_next.send = send_go;
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			st_reg <= ST_IDLE;
			ps_reg <= PS_A;
			cmd_reg <= '0;
			evt_cnt_reg <= '0;
			plus_reg <= '0;
			cmd_ch_reg <= '0;
			boot_reg <= 1'b1;
			cfg_stb_reg <= 1'b0;
			warn_reg <= 1'b0;
			conn_go_reg <= 1'b0;
			noc_go_reg <= 1'b0;
			rx_rdy_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			ps_reg <= ps_next;
			cmd_reg <= cmd_next;
			evt_cnt_reg <= evt_cnt_next;
			plus_reg <= plus_next;
			cmd_ch_reg <= cmd_ch_next;
			boot_reg <= boot_next;
			cfg_stb_reg <= cfg_stb_next;
			warn_reg <= warn_next;
			conn_go_reg <= conn_go_next;
			noc_go_reg <= noc_go_next;
			rx_rdy_reg <= rx_rdy_next;
		end
	end

	// ----------------------------------------
	// network transmit, UDP blocks, peer
	// ----------------------------------------
	assign learn = (CFG.peer_ip == '0) && (CFG.peer_port == '0);
	assign blk = (CFG.block_size == '0 || CFG.block_size > BLOCK_MAX) ? BLOCK_MAX : CFG.block_size;
	assign gate = is_udp ? ((!learn || learned_reg) && udp_cnt_reg < blk) : (st_reg == ST_ONLINE);
	assign fifo_pop = gate && fifo_out_valid && (!tx_valid_reg || NET_TX_READY);
	assign size_hit = (udp_cnt_reg == blk);
	assign idle_hit = (CFG.frame_10ms != '0) && (frame_reg >= CFG.frame_10ms) && (udp_cnt_reg != '0)
		&& !fifo_out_valid;
	assign send_go = is_udp && !tx_valid_reg && !cmd_reg.send && (size_hit || idle_hit);

	always_comb begin
		tx_valid_next = fifo_pop ? 1'b1 : (NET_TX_READY ? 1'b0 : tx_valid_reg);
		tx_data_next = fifo_pop ? fifo_out_data : tx_data_reg;
		udp_cnt_next = udp_cnt_reg + 11'(fifo_pop);
		if (send_go) begin
			udp_cnt_next = '0;
		end
		dst_next = learn ? dst_reg : {CFG.peer_ip, CFG.peer_port};
		learned_next = learn && (learned_reg || NET_STAT.udp_rx);
		if (learn && NET_STAT.udp_rx) dst_next = {NET_STAT.src_ip, NET_STAT.src_port};
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			tx_valid_reg <= 1'b0;
			tx_data_reg <= '0;
			udp_cnt_reg <= '0;
			dst_reg <= '0;
			learned_reg <= 1'b0;
		end else begin
			tx_valid_reg <= tx_valid_next;
			tx_data_reg <= tx_data_next;
			udp_cnt_reg <= udp_cnt_next;
			dst_reg <= dst_next;
			learned_reg <= learned_next;
		end
	end

	// ----------------------------------------
	// serial messages
	// ----------------------------------------
	always_comb begin
		pc_next = pc_reg || conn_go_reg;
		pn_next = pn_reg || noc_go_reg;
		busy_next = busy_reg;
		sel_next = sel_reg;
		idx_next = idx_reg;
		stx_v_next = stx_v_reg;
		stx_d_next = stx_d_reg;
		if (SER_TX_READY || !stx_v_reg) begin
			stx_v_next = 1'b0;
			if (busy_reg) begin
				stx_v_next = 1'b1;
				stx_d_next = sel_reg ? MSG_NOC[8 * (MSG_NOC_LEN - 4'h1 - idx_reg) +: 8]
					: MSG_CONN[8 * (MSG_CONN_LEN - 4'h1 - idx_reg) +: 8];
				busy_next = (idx_reg != (sel_reg ? MSG_NOC_LEN : MSG_CONN_LEN) - 4'h1);
				idx_next = idx_reg + 4'h1;
			end else if (pc_reg || pn_reg) begin
				busy_next = 1'b1;
				sel_next = !pc_reg;
				idx_next = '0;
				if (pc_reg) pc_next = conn_go_reg;
				else pn_next = noc_go_reg;
			end
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			pc_reg <= 1'b0;
			pn_reg <= 1'b0;
			busy_reg <= 1'b0;
			sel_reg <= 1'b0;
			idx_reg <= '0;
			stx_v_reg <= 1'b0;
			stx_d_reg <= '0;
		end else begin
			pc_reg <= pc_next;
			pn_reg <= pn_next;
			busy_reg <= busy_next;
			sel_reg <= sel_next;
			idx_reg <= idx_next;
			stx_v_reg <= stx_v_next;
			stx_d_reg <= stx_d_next;
		end
	end

	assign SER_RX_READY = rx_rdy_reg;
	assign SER_TX_VALID = stx_v_reg;
	assign SER_TX_DATA = stx_d_reg;
	assign NET_CMD = cmd_reg;
	assign NET_TX_VALID = tx_valid_reg;
	assign NET_TX_DATA = tx_data_reg;
	assign NET_DST = dst_reg;
	assign CFG_CMD_STB = cfg_stb_reg;
	assign CFG_WARN = warn_reg;
	assign SESSION_ST = st_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_B);

	property p_boot_conn;
		(st_reg == ST_IDLE && CFG.mode == M_CLIENT && CFG.event_bytes == '0) |=> NET_CMD.connect;
	endproperty
	a_boot_conn: assert property (p_boot_conn) else $error("no connect in client idle");

	property p_trig_conn;
		(NET_CMD.connect && CFG.mode != M_ATCMD && CFG.event_bytes != '0)
			|-> ($past(evt_cnt_reg) >= CFG.event_bytes || $past(!fifo_in_rdy));
	endproperty
	a_trig_conn: assert property (p_trig_conn) else $error("connect before trigger count");

	property p_drop;
		!(fifo_push && !is_at && !is_udp && CFG.event_bytes == '0 && st_reg != ST_ONLINE);
	endproperty
	a_drop: assert property (p_drop) else $error("byte held while it must drop");

	property p_timeout_fin;
		(to_hit && st_reg == ST_ONLINE && !NET_STAT.closed) |=> (NET_CMD.fin && st_reg == ST_CLOSING);
	endproperty
	a_timeout_fin: assert property (p_timeout_fin) else $error("no FIN on idle timeout");

	property p_one_conn;
		NET_CMD.listen |-> !(st_reg == ST_SYN || st_reg == ST_ONLINE || st_reg == ST_CMD);
	endproperty
	a_one_conn: assert property (p_one_conn) else $error("listening while connected");

	property p_connect_msg;
		(conn_go_reg && !busy_reg && !pn_reg && !pc_reg) ##1 SER_TX_READY [*2]
			|=> (SER_TX_VALID && SER_TX_DATA == CH_CR);
	endproperty
	a_connect_msg: assert property (p_connect_msg) else $error("CONNECT text not started");

	property p_escape;
		escape && !NET_STAT.closed && !to_hit |=> (st_reg == ST_CMD && !NET_CMD.fin);
	endproperty
	a_escape: assert property (p_escape) else $error("escape did not enter command state");

	property p_hangup;
		(st_reg == ST_CMD && exec && (cmd_ch_reg & CASE_MASK) == CH_H && !NET_STAT.closed)
			|=> NET_CMD.fin ##1 !NET_CMD.fin;
	endproperty
	a_hangup: assert property (p_hangup) else $error("hang-up gave no single FIN");

	property p_block_send;
		(is_udp && size_hit && !tx_valid_reg && !NET_CMD.send) |=> (NET_CMD.send && udp_cnt_reg == '0);
	endproperty
	a_block_send: assert property (p_block_send) else $error("full block not sent");

	property p_no_peer;
		(is_udp && learn && !learned_reg) |-> !fifo_pop;
	endproperty
	a_no_peer: assert property (p_no_peer) else $error("UDP data before peer learned");

	property p_learn;
		(learn && NET_STAT.udp_rx) |=> (NET_DST.ip == $past(NET_STAT.src_ip) && learned_reg);
	endproperty
	a_learn: assert property (p_learn) else $error("peer not learned");

	c_online: cover property (st_reg == ST_SYN ##[1:50] st_reg == ST_ONLINE);
	c_cmd_state: cover property (st_reg == ST_ONLINE ##[1:50] st_reg == ST_CMD);
	c_udp_idle_send: cover property (idle_hit && is_udp ##1 NET_CMD.send);
endmodule
`default_nettype wire

// [verilog/snsc_pkg.sv]
`default_nettype none
package snsc_pkg;

	// ----------------------------------------
	// modes, states, carriers
	// ----------------------------------------
	typedef enum logic [2:0] {
		M_SERVER = 3'h0,
		M_CLIENT = 3'h1,
		M_SRVCLI = 3'h2,
		M_ATCMD = 3'h3,
		M_UDP = 3'h4
	} mode_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_LISTEN = 3'h1,
		ST_SYN = 3'h2,
		ST_ONLINE = 3'h3,
		ST_CMD = 3'h4,
		ST_CLOSING = 3'h5
	} sess_st_t;

	typedef enum logic [1:0] {
		PS_A = 2'h0,
		PS_T = 2'h1,
		PS_C = 2'h2,
		PS_EOL = 2'h3
	} parse_st_t;

	typedef struct packed {
		mode_t mode;
		logic [15:0] event_bytes;
		logic [15:0] timeout_s;
		logic [10:0] block_size;
		logic [15:0] frame_10ms;
		logic [31:0] peer_ip;
		logic [15:0] peer_port;
	} cfg_t;

	typedef struct packed {
		logic established;
		logic closed;
		logic rx_act;
		logic udp_rx;
		logic [31:0] src_ip;
		logic [15:0] src_port;
	} net_stat_t;

	typedef struct packed {
		logic listen;
		logic connect;
		logic fin;
		logic send;
	} net_cmd_t;

	typedef struct packed {
		logic [31:0] ip;
		logic [15:0] port;
	} peer_t;

	// ----------------------------------------
	// timing and sizes
	// ----------------------------------------
	localparam int CLK_KHZ = 125000;
	localparam int FRAME_UNIT_MS = 10;
	localparam int TICK_CYC = FRAME_UNIT_MS * CLK_KHZ;
	localparam int TICKS_PER_SEC = 1000 / FRAME_UNIT_MS;
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;
	localparam logic [15:0] EVT_REC_MAX = 16'h0200;
	localparam logic [10:0] BLOCK_MAX = 11'h5B4;
	localparam logic [1:0] ESC_LAST = 2'h2;

	// ----------------------------------------
	// characters and messages
	// ----------------------------------------
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_T = 8'h54;
	localparam logic [7:0] CH_D = 8'h44;
	localparam logic [7:0] CH_H = 8'h48;
	localparam logic [7:0] CH_O = 8'h4F;
	localparam logic [7:0] CH_PLUS = 8'h2B;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CASE_MASK = 8'hDF;
	localparam logic [3:0] MSG_CONN_LEN = 4'hB;
	localparam logic [3:0] MSG_NOC_LEN = 4'hE;
	localparam logic [87:0] MSG_CONN = "\r\nCONNECT\r\n";
	localparam logic [111:0] MSG_NOC = "\r\nNO CARRIER\r\n";

endpackage
`default_nettype wire

// [verilog/snsc_fifo.sv]
`default_nettype none
module snsc_fifo import snsc_pkg::*; #(
	parameter int W = FIFO_WIDTH,
	parameter int D = FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready,
	output logic [$clog2(D+1)-1:0] level
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D + 1);

	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic rdy_reg, rdy_next, vld_reg, vld_next;
	logic push, pop;

	assign push = in_valid && rdy_reg;
	assign pop = out_ready && vld_reg;
	assign in_ready = rdy_reg;
	assign out_valid = vld_reg;
	assign out_data = mem[rd_reg];
	assign level = cnt_reg;

	// ----------------------------------------
	// pointers and flags
	// ----------------------------------------
	always_comb begin
		wr_next = wr_reg;
		rd_next = rd_reg;
		if (push) begin
			wr_next = (wr_reg == AW'(D - 1)) ? '0 : wr_reg + 1'b1;
		end
		if (pop) begin
			rd_next = (rd_reg == AW'(D - 1)) ? '0 : rd_reg + 1'b1;
		end
		cnt_next = cnt_reg + CW'(push) - CW'(pop);
		rdy_next = (cnt_next != CW'(D));
		vld_next = (cnt_next != '0);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
			rdy_reg <= 1'b1;
			vld_reg <= 1'b0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
			rdy_reg <= rdy_next;
			vld_reg <= vld_next;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_fifo_bound;
		@(posedge clk) disable iff (!rst_b) cnt_reg <= CW'(D);
	endproperty
	a_fifo_bound: assert property (p_fifo_bound) else $error("fifo level above depth");

	c_fifo_full: cover property (@(posedge clk) disable iff (!rst_b) !rdy_reg);
endmodule
`default_nettype wire

// [sim/net_far.sv]
`default_nettype none
module net_far import snsc_pkg::*; (
	input wire logic clk,
	input wire logic slow,
	input wire net_cmd_t cmd,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output net_stat_t stat
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// remote host: answers connect and fin
	// ----------------------------------------
	logic [7:0] got[$];
	logic [47:0] src;
	logic inj = 1'b0;
	logic ph = 1'b0;
	int cdel = 0;
	int fdel = 0;
	initial stat = '0;
	initial tx_ready = 1'b0;
	task udp(input logic [47:0] s);
		src = s;
		inj = 1'b1;
	endtask
	always @(posedge clk) begin
		ph <= ~ph;
		tx_ready <= slow ? ph : 1'b1;
		stat.established <= cdel == 1;
		stat.closed <= fdel == 1;
		stat.rx_act <= 1'b0;
		stat.udp_rx <= inj;
		// source fields are garbage outside the pulse
		{stat.src_ip, stat.src_port} <= inj ? src : ~{stat.src_ip, stat.src_port};
		inj <= 1'b0;
		cdel <= cmd.connect ? (slow ? 40 : 3) : (cdel > 0 ? cdel - 1 : 0);
		fdel <= cmd.fin ? 3 : (fdel > 0 ? fdel - 1 : 0);
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
	end
endmodule
`default_nettype wire

// [sim/testbench.sv]
`default_nettype none
module testbench import snsc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic MCLK = 1'b0;
	logic RST_B = 1'b0;
	cfg_t CFG = '0;
	logic SER_RX_VALID = 1'b0;
	logic [7:0] SER_RX_DATA = 8'h00;
	logic SER_RX_READY, SER_TX_VALID, NET_TX_VALID, NET_TX_READY, CFG_CMD_STB, CFG_WARN;
	logic [7:0] SER_TX_DATA, NET_TX_DATA;
	net_stat_t NET_STAT;
	net_cmd_t NET_CMD;
	peer_t NET_DST;
	sess_st_t SESSION_ST;
	logic slow = 1'b1;
	logic [7:0] sq[$];
	int n_mismatch = 0;
	int comparisons = 0;
	int n_conn, n_fin, n_send, n_cfg;
	always #4 MCLK = ~MCLK;
	snsc_session #(.TICK_CYC_P(10), .DEPTH(FIFO_DEPTH)) dut (.MCLK(MCLK), .RST_B(RST_B), .CFG(CFG),
		.SER_RX_VALID(SER_RX_VALID), .SER_RX_DATA(SER_RX_DATA), .SER_RX_READY(SER_RX_READY),
		.SER_TX_VALID(SER_TX_VALID), .SER_TX_DATA(SER_TX_DATA), .SER_TX_READY(1'b1), .NET_STAT(NET_STAT),
		.NET_CMD(NET_CMD), .NET_TX_VALID(NET_TX_VALID), .NET_TX_DATA(NET_TX_DATA), .NET_TX_READY(NET_TX_READY),
		.NET_DST(NET_DST), .CFG_CMD_STB(CFG_CMD_STB), .CFG_WARN(CFG_WARN), .SESSION_ST(SESSION_ST));
	net_far far (.clk(MCLK), .slow(slow), .cmd(NET_CMD), .tx_valid(NET_TX_VALID), .tx_data(NET_TX_DATA),
		.tx_ready(NET_TX_READY), .stat(NET_STAT));
	always @(posedge MCLK) begin
		if (NET_CMD.connect === 1'b1) n_conn++;
		if (NET_CMD.fin === 1'b1) n_fin++;
		if (NET_CMD.send === 1'b1) n_send++;
		if (CFG_CMD_STB === 1'b1) n_cfg++;
		if (SER_TX_VALID === 1'b1) sq.push_back(SER_TX_DATA);
	end
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task end_sim;
		if (n_mismatch == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input bit ok, input string m);
		comparisons++;
		if (!ok) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask
	task boot(input mode_t m, input logic [15:0] ev, input logic [15:0] to, input logic [15:0] fr,
		input logic [47:0] pr);
		RST_B = 1'b0;
		CFG = '{m, ev, to, 11'h002, fr, pr[47:16], pr[15:0]};
		cyc(6);
		far.got.delete();
		sq.delete();
		n_conn = 0;
		n_fin = 0;
		n_send = 0;
		n_cfg = 0;
		RST_B = 1'b1;
	endtask
	task put(input string s);
		for (int i = 0; i < s.len(); i++) begin
			SER_RX_VALID = 1'b1;
			SER_RX_DATA = s[i];
			while (SER_RX_READY !== 1'b1)
				cyc(1);
			cyc(1);
		end
		SER_RX_VALID = 1'b0;
		cyc(1);
	endtask
	function automatic string q2s(input logic [7:0] q[$]);
		string r = "";
		foreach (q[i])
			r = $sformatf("%s%c", r, q[i]);
		return r;
	endfunction
	initial begin
		#200000;
		n_mismatch++;
		end_sim;
	end
	initial begin
		boot(M_CLIENT, 16'h0000, 16'h0001, 16'h0000, 48'h0A0000021F40);
		put("12");
		cyc(80);
		chk(n_conn == 1 && SESSION_ST === ST_ONLINE, "no connect at boot");
		put("9");
		cyc(20);
		chk(q2s(far.got) == "9", "early bytes not dropped");
		cyc(930);
		chk(n_fin == 0, "early idle close");
		cyc(100);
		chk(n_fin == 1, "no fin after idle second");
		boot(M_CLIENT, 16'h0003, 16'h0000, 16'h0000, 48'h0A0000021F40);
		put("ab");
		cyc(10);
		chk(n_conn == 0, "connect before trigger count");
		put("cdefghij");
		cyc(120);
		chk(n_conn == 1 && q2s(far.got) == "abcdefghij", "held bytes lost or reordered");
		slow = 1'b0;
		boot(M_UDP, 16'h0000, 16'h0000, 16'h0002, 48'h0A0000021F40);
		put("xyz");
		cyc(8);
		chk(n_send == 1, "no send at block length");
		cyc(40);
		chk(n_send == 2 && q2s(far.got) == "xyz", "no send after idle frame");
		boot(M_UDP, 16'h0258, 16'h0000, 16'h0002, 48'h000000000000);
		put("pq");
		cyc(40);
		chk(CFG_WARN === 1'b1, "large trigger not flagged");
		chk(n_send == 0 && far.got.size() == 0, "sent before peer known");
		far.udp(48'hC0A8000A1388);
		cyc(3);
		chk(NET_DST === 48'hC0A8000A1388, "peer not learned");
		cyc(20);
		chk(n_send == 1 && q2s(far.got) == "pq", "no send to learned peer");
		boot(M_ATCMD, 16'h0000, 16'h0000, 16'h0000, 48'h0A0000021F40);
		put("at+pto=5\r");
		put("ATD\r");
		cyc(40);
		chk(n_cfg == 1 && n_conn == 1 && q2s(sq) == "\r\nCONNECT\r\n", "dial");
		put("+++");
		cyc(3);
		chk(SESSION_ST === ST_CMD, "escape not taken");
		put("ATO\r");
		cyc(3);
		chk(SESSION_ST === ST_ONLINE, "not back online");
		put("+++ATH\r");
		cyc(40);
		chk(n_fin == 1 && q2s(sq) == "\r\nCONNECT\r\n\r\nNO CARRIER\r\n", "hang-up");
		put("ATA\r");
		cyc(3);
		chk(NET_CMD.listen === 1'b1, "answer does not listen");
		boot(M_SRVCLI, 16'h0002, 16'h0001, 16'h0000, 48'h0A0000021F40);
		cyc(2);
		chk(NET_CMD.listen === 1'b1 && SESSION_ST === ST_LISTEN, "combined mode not listening");
		put("uv");
		cyc(30);
		chk(n_conn == 1 && NET_CMD.listen === 1'b0 && q2s(far.got) == "uv", "no dial in combined mode");
		end_sim;
	end
endmodule
`default_nettype wire
